// ---- rtl/wdog_pkg.sv ----
// ============================================================
// Shared constants and types of the windowed watchdog.
// ============================================================
package wdog_pkg;

	// Counter, address and data widths.
	localparam int CW = 24;
	localparam int AW = 12;
	localparam int DW = 32;

	// Register byte offsets.
	localparam logic [AW-1:0] OFS_MODE = 12'h000;
	localparam logic [AW-1:0] OFS_RELOAD = 12'h004;
	localparam logic [AW-1:0] OFS_FEED = 12'h008;
	localparam logic [AW-1:0] OFS_COUNT = 12'h00C;
	localparam logic [AW-1:0] OFS_WARN = 12'h014;
	localparam logic [AW-1:0] OFS_WINDOW = 12'h018;

	// Mode control field positions.
	localparam int BIT_EN = 0;
	localparam int BIT_RSTEN = 1;
	localparam int BIT_TIMEOUT = 2;
	localparam int BIT_WARN = 3;
	localparam int BIT_PROTECT = 4;
	localparam int BIT_LOCK = 5;

	// Reset values and counter landmarks.
	localparam logic [CW-1:0] RELOAD_RST = 24'h0000FF;
	localparam logic [CW-1:0] COUNT_RST = 24'h0000FF;
	localparam logic [CW-1:0] WARN_RST = 24'h000000;
	localparam logic [CW-1:0] WINDOW_RST = 24'hFFFFFF;
	localparam logic [CW-1:0] MIN_LOAD = 24'h0000FF;
	localparam logic [CW-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CW-1:0] CNT_ONE = 24'h000001;

	// Feed unlock keys, compared against the low data byte.
	localparam logic [7:0] FEED_KEY1 = 8'hAA;
	localparam logic [7:0] FEED_KEY2 = 8'h55;

	// Count clocks per counter step, and count clock edges a new setting needs.
	localparam int PRESCALE = 4;
	localparam int SYNC_STAGES = 3;

	// Settings that cross into the counting logic.
	typedef struct packed {
		logic en;
		logic rstEn;
		logic [CW-1:0] reload;
	} wdog_cfg_t;

	localparam wdog_cfg_t CFG_RST = '{en: 1'b0, rstEn: 1'b0, reload: RELOAD_RST};

	// APB request signals from the processor.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [AW-1:0] paddr;
		logic [DW-1:0] pwdata;
	} wdog_apb_req_t;

endpackage : wdog_pkg

// ---- rtl/wdog_tick_gen.sv ----
`timescale 1ns/100ps
// ============================================================
// Count clock synchroniser and fixed prescaler.
// ============================================================
module wdog_tick_gen
	import wdog_pkg::*;
#(
	parameter int PRESCALE_DIV = PRESCALE
) (
	input wire logic core_clk, // Peripheral bus clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic countClock, // Watchdog oscillator, asynchronous to core_clk.
	input wire logic run, // Counter is running; the prescaler idles otherwise.
	output logic countEdge, // One pulse per rising count clock edge.
	output logic countTick // One pulse per PRESCALE_DIV count clock edges.
);

	localparam int PW = $clog2(PRESCALE_DIV);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);
	localparam logic [PW-1:0] PRE_ZERO = '0;

	logic meta_r; // First stage, read by syncd_r only.
	logic syncd_r; // Second stage, safe to use.
	logic prev_r; // Delayed copy for edge detection.
	logic edge_r, edge_nxt;
	logic tick_r, tick_nxt;
	logic [PW-1:0] presc_r, presc_nxt;

	// ============================================================
	// Next state.
	// ============================================================
	// The oscillator is far slower than core_clk, so sampling it as a level
	// loses no edge; faster oscillators would need a real second domain.
	always_comb begin
		edge_nxt = syncd_r && !prev_r;
		tick_nxt = 1'b0;
		presc_nxt = presc_r;
		if (!run) begin
			// Held in step so the first interval after a start is full.
			presc_nxt = PRE_ZERO;
		end else if (edge_nxt) begin
			tick_nxt = (presc_r == PRE_LAST);
			presc_nxt = (presc_r == PRE_LAST) ? PRE_ZERO : presc_r + 1'b1;
		end
	end

	// Registers only.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= 1'b0;
			syncd_r <= 1'b0;
			prev_r <= 1'b0;
			edge_r <= 1'b0;
			tick_r <= 1'b0;
			presc_r <= PRE_ZERO;
		end else begin
			meta_r <= countClock;
			syncd_r <= meta_r;
			prev_r <= syncd_r;
			edge_r <= edge_nxt;
			tick_r <= tick_nxt;
			presc_r <= presc_nxt;
		end
	end

	assign countEdge = edge_r;
	assign countTick = tick_r;

endmodule : wdog_tick_gen

// ---- rtl/wdog_timer.sv ----
`timescale 1ns/100ps
// Summary of operation
// - 24-bit counter steps every four count clocks.
// - Reload below 0xFF loads 0xFF instead.
// - Write 0xAA then 0x55 reloads counter.
// - Counter reaching zero while running is event.
// - Feed above window value is an event.
// - Wrong feed sequence is immediate event when enabled.
// - Zero count with reset enable requests chip reset.
// - Timeout flag survives watchdog reset; software clears.
// - Counter equal to warning value raises warning.
// - Enable, reset enable and reload take effect three count clocks later.
// - Counter captured at count edge, then read.
// - Mode bit 5 locks the count clock on.
// - Protected reload changes only below warning and window.
// - Reload protection clears only on a reset.
// - Once enabled, stays enabled until a reset.
// - Reload constant is 24 bits, resets to 0xFF.
// - Window compare resets to all ones.
// - Count value reads counter, resets to 0xFF.
// - Registers and counter on bus clock, counter stepped by count clock.
// - Enable and reset enable bits are set-only.
// - Warning flag set at compare, cleared by zero.
// - Reset enable chooses warning only or reset too.
module wdog_timer
	import wdog_pkg::*;
(
	input wire logic core_clk, // Peripheral bus clock.
	input wire logic sys_rst, // External reset, asynchronous, active high.
	input wire logic chipRst, // Synchronous pulse: chip reset caused by the watchdog.
	input wire logic countClock, // Watchdog oscillator clock, asynchronous.
	input wire wdog_apb_req_t apbReq, // APB request from the processor.
	output logic [DW-1:0] prdata, // APB read data.
	output logic pready, // APB ready; never stalls.
	output logic pslverr, // APB error for an unmapped address.
	output logic warnIrq, // Warning interrupt request, a level.
	output logic chipResetReq, // Chip reset request, one-cycle pulse.
	output logic clockLock // Keeps the count clock source powered.
);

	// ============================================================
	// Prescaler and count clock sampling.
	// ============================================================
	logic countEdge; // One pulse per count clock edge.
	logic countTick; // One pulse per counter step.
	logic running_r, running_nxt; // Counter started by a feed.

	wdog_tick_gen u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.countClock(countClock),
		.run(running_r),
		.countEdge(countEdge),
		.countTick(countTick)
	);

	// ============================================================
	// Bus decode.
	// ============================================================
	logic acc; // Access phase of any transfer.
	logic wr; // Access phase of a write.
	logic setup; // Setup phase, when read data is prepared.
	logic mapped; // Address names a register.
	logic feedAcc; // Any access to the feed register.
	logic [7:0] keyByte; // Low data byte, compared against the keys.

	always_comb begin
		acc = apbReq.psel && apbReq.penable;
		wr = acc && apbReq.pwrite;
		setup = apbReq.psel && !apbReq.penable;
		mapped = (apbReq.paddr == OFS_MODE) || (apbReq.paddr == OFS_RELOAD) ||
			(apbReq.paddr == OFS_FEED) || (apbReq.paddr == OFS_COUNT) ||
			(apbReq.paddr == OFS_WARN) || (apbReq.paddr == OFS_WINDOW);
		feedAcc = acc && (apbReq.paddr == OFS_FEED);
		keyByte = apbReq.pwdata[7:0];
	end

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// ============================================================
	// Software visible state.
	// ============================================================
	logic en_r, en_nxt; // Run enable.
	logic rstEn_r, rstEn_nxt; // Reset generation enable.
	logic timeoutFlag_r, timeoutFlag_nxt; // Sticky event flag.
	logic warnFlag_r, warnFlag_nxt; // Sticky warning flag.
	logic protect_r, protect_nxt; // Reload protection.
	logic lock_r, lock_nxt; // Count clock lock.
	logic feedArmed_r, feedArmed_nxt; // First key seen.
	logic [CW-1:0] reloadReg_r, reloadReg_nxt;
	logic [CW-1:0] warnReg_r, warnReg_nxt;
	logic [CW-1:0] windowReg_r, windowReg_nxt;

	// Counting side state, declared here for the event terms.
	wdog_cfg_t cfgPipe_r [SYNC_STAGES];
	wdog_cfg_t cfgPipe_nxt [SYNC_STAGES];
	wdog_cfg_t cfgEff; // Settings as the counter sees them.
	logic [CW-1:0] counter_r, counter_nxt;
	logic [CW-1:0] snapshot_r, snapshot_nxt;
	logic [CW-1:0] loadVal; // Value a feed loads.

	// Event terms.
	logic feedKey, feedOk, feedErr, windowErr, protectErr, timeoutEv, warnEv, anyEv;
	logic protectOpen; // Counter below both warning and window values.
	logic chipResetReq_r, chipResetReq_nxt;

	assign cfgEff = cfgPipe_r[SYNC_STAGES-1];

	// Events. A feed reload wins over a counter step in the same cycle.
	always_comb begin
		loadVal = (cfgEff.reload < MIN_LOAD) ? MIN_LOAD : cfgEff.reload;
		feedKey = feedAcc && apbReq.pwrite && feedArmed_r && (keyByte == FEED_KEY2);
		feedOk = feedKey && cfgEff.en;
		// Any access other than the second key while armed, or any feed access
		// other than a first key while idle, breaks the sequence.
		feedErr = cfgEff.en && !feedKey && (feedArmed_r ? acc :
			(feedAcc && !(apbReq.pwrite && keyByte == FEED_KEY1)));
		windowErr = feedOk && running_r && (counter_r > windowReg_r);
		protectOpen = (counter_r < warnReg_r) && (counter_r < windowReg_r);
		protectErr = wr && (apbReq.paddr == OFS_RELOAD) && protect_r && !protectOpen;
		timeoutEv = countTick && running_r && !feedOk && (counter_r == CNT_ONE);
		warnEv = countTick && running_r && !feedOk && (counter_r == warnReg_r);
		anyEv = timeoutEv || windowErr || feedErr || protectErr;
		chipResetReq_nxt = anyEv && cfgEff.rstEn;
	end

	// Register writes, then hardware sets, so an event beats a clear.
	always_comb begin
		en_nxt = en_r;
		rstEn_nxt = rstEn_r;
		timeoutFlag_nxt = timeoutFlag_r;
		warnFlag_nxt = warnFlag_r;
		protect_nxt = protect_r;
		lock_nxt = lock_r;
		reloadReg_nxt = reloadReg_r;
		warnReg_nxt = warnReg_r;
		windowReg_nxt = windowReg_r;
		feedArmed_nxt = feedArmed_r;
		if (chipRst) begin
			// Watchdog reset: everything but the timeout flag returns home.
			en_nxt = 1'b0;
			rstEn_nxt = 1'b0;
			warnFlag_nxt = 1'b0;
			protect_nxt = 1'b0;
			lock_nxt = 1'b0;
			reloadReg_nxt = RELOAD_RST;
			warnReg_nxt = WARN_RST;
			windowReg_nxt = WINDOW_RST;
			feedArmed_nxt = 1'b0;
		end else begin
			if (acc) begin
				// Only a first key while idle arms; every other access disarms.
				feedArmed_nxt = feedAcc && apbReq.pwrite && !feedArmed_r && (keyByte == FEED_KEY1);
			end
			if (wr) begin
				unique case (apbReq.paddr)
					OFS_MODE: begin
						en_nxt = en_r || apbReq.pwdata[BIT_EN];
						rstEn_nxt = rstEn_r || apbReq.pwdata[BIT_RSTEN];
						if (!apbReq.pwdata[BIT_TIMEOUT]) begin
							timeoutFlag_nxt = 1'b0;
						end
						if (!apbReq.pwdata[BIT_WARN]) begin
							warnFlag_nxt = 1'b0;
						end
						protect_nxt = protect_r || apbReq.pwdata[BIT_PROTECT];
						lock_nxt = lock_r || apbReq.pwdata[BIT_LOCK];
					end
					OFS_RELOAD: begin
						if (!protectErr) begin
							reloadReg_nxt = apbReq.pwdata[CW-1:0];
						end
					end
					OFS_WARN: warnReg_nxt = apbReq.pwdata[CW-1:0];
					OFS_WINDOW: windowReg_nxt = apbReq.pwdata[CW-1:0];
					default: ; // Feed, read-only and unmapped writes store nothing.
				endcase
			end
		end
		if (anyEv) begin
			timeoutFlag_nxt = 1'b1;
		end
		if (warnEv) begin
			warnFlag_nxt = 1'b1;
		end
	end

	// Software state registers. Of the two resets, only the external reset clears the timeout flag.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_r <= 1'b0;
			rstEn_r <= 1'b0;
			timeoutFlag_r <= 1'b0;
			warnFlag_r <= 1'b0;
			protect_r <= 1'b0;
			lock_r <= 1'b0;
			feedArmed_r <= 1'b0;
			reloadReg_r <= RELOAD_RST;
			warnReg_r <= WARN_RST;
			windowReg_r <= WINDOW_RST;
			chipResetReq_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			rstEn_r <= rstEn_nxt;
			timeoutFlag_r <= timeoutFlag_nxt;
			warnFlag_r <= warnFlag_nxt;
			protect_r <= protect_nxt;
			lock_r <= lock_nxt;
			feedArmed_r <= feedArmed_nxt;
			reloadReg_r <= reloadReg_nxt;
			warnReg_r <= warnReg_nxt;
			windowReg_r <= windowReg_nxt;
			chipResetReq_r <= chipResetReq_nxt;
		end
	end

	// ============================================================
	// Counting side.
	// ============================================================
	// Settings ride a pipeline advanced by count clock edges, so they act
	// only after SYNC_STAGES oscillator cycles. Software that protects the
	// reload too soon after a feed may race this pipeline.
	always_comb begin
		for (int i = 0; i < SYNC_STAGES; i++) begin
			cfgPipe_nxt[i] = cfgPipe_r[i];
		end
		running_nxt = running_r || feedOk;
		counter_nxt = counter_r;
		snapshot_nxt = snapshot_r;
		if (chipRst) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				cfgPipe_nxt[i] = CFG_RST;
			end
			running_nxt = 1'b0;
			counter_nxt = COUNT_RST;
			snapshot_nxt = COUNT_RST;
		end else begin
			if (countEdge) begin
				cfgPipe_nxt[0] = '{en: en_r, rstEn: rstEn_r, reload: reloadReg_r};
				for (int i = 1; i < SYNC_STAGES; i++) begin
					cfgPipe_nxt[i] = cfgPipe_r[i-1];
				end
				snapshot_nxt = counter_r;
			end
			if (feedOk) begin
				counter_nxt = loadVal;
			end else if (countTick && running_r && counter_r != CNT_ZERO) begin
				counter_nxt = counter_r - CNT_ONE;
			end
		end
	end

	// Counting registers.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				cfgPipe_r[i] <= CFG_RST;
			end
			running_r <= 1'b0;
			counter_r <= COUNT_RST;
			snapshot_r <= COUNT_RST;
		end else begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				cfgPipe_r[i] <= cfgPipe_nxt[i];
			end
			running_r <= running_nxt;
			counter_r <= counter_nxt;
			snapshot_r <= snapshot_nxt;
		end
	end

	// ============================================================
	// Read data, prepared in the setup phase.
	// ============================================================
	logic [DW-1:0] prdata_r, prdata_nxt;

	// Reserved and unmapped bits read as zero; the feed register reads zero.
	always_comb begin
		prdata_nxt = prdata_r;
		if (setup) begin
			prdata_nxt = '0;
			case (apbReq.paddr)
				OFS_MODE: begin
					prdata_nxt[BIT_EN] = en_r;
					prdata_nxt[BIT_RSTEN] = rstEn_r;
					prdata_nxt[BIT_TIMEOUT] = timeoutFlag_r;
					prdata_nxt[BIT_WARN] = warnFlag_r;
					prdata_nxt[BIT_PROTECT] = protect_r;
					prdata_nxt[BIT_LOCK] = lock_r;
				end
				OFS_RELOAD: prdata_nxt[CW-1:0] = reloadReg_r;
				OFS_COUNT: prdata_nxt[CW-1:0] = snapshot_r;
				OFS_WARN: prdata_nxt[CW-1:0] = warnReg_r;
				OFS_WINDOW: prdata_nxt[CW-1:0] = windowReg_r;
				default: prdata_nxt = '0;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_r <= '0;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign warnIrq = warnFlag_r;
	assign chipResetReq = chipResetReq_r;
	assign clockLock = lock_r;

	// ============================================================
	// Checks.
	// ============================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// First key, then the next access two or three cycles on, with or without an idle cycle.
	sequence keyFirst;
		feedAcc && apbReq.pwrite && !feedArmed_r && keyByte == FEED_KEY1;
	endsequence
	sequence keySecond;
		feedAcc && apbReq.pwrite && keyByte == FEED_KEY2;
	endsequence

	step_only_tick_a: assert property (!countTick && !feedOk && !chipRst |=> $stable(counter_r))
		else $error("Counter moved without a tick or feed.");
	min_load_a: assert property (feedOk && cfgEff.reload < MIN_LOAD |=> counter_r == MIN_LOAD)
		else $error("Short reload did not load the minimum.");
	feed_pair_a: assert property (keyFirst ##[2:3] keySecond ##0 (cfgEff.en && !chipRst) |=> counter_r == $past(loadVal))
		else $error("Feed pair did not reload the counter.");
	zero_event_a: assert property (timeoutEv && !chipRst |=> timeoutFlag_r && counter_r == CNT_ZERO)
		else $error("Reaching zero did not flag an event.");
	early_feed_a: assert property (feedOk && running_r && counter_r > windowReg_r |=> timeoutFlag_r)
		else $error("Early feed was not flagged.");
	bad_feed_a: assert property (keyFirst ##[2:3] (wr && !feedAcc && cfgEff.en) |=> timeoutFlag_r)
		else $error("Broken feed sequence was not flagged.");
	chip_reset_a: assert property (timeoutEv && cfgEff.rstEn |=> chipResetReq ##1 !chipResetReq)
		else $error("Timeout did not pulse the chip reset request.");
	flag_keep_a: assert property (chipRst && timeoutFlag_r |=> timeoutFlag_r)
		else $error("Watchdog reset cleared the timeout flag.");
	warn_flag_a: assert property (warnEv |=> warnIrq)
		else $error("Warning compare did not raise the interrupt.");
	cfg_hold_a: assert property (!countEdge && !chipRst |=> $stable(cfgEff))
		else $error("Settings changed between count clock edges.");
	snap_take_a: assert property (countEdge && !chipRst |=> snapshot_r == $past(counter_r))
		else $error("Count snapshot not taken at a count edge.");
	protect_block_a: assert property (protectErr && !chipRst |=> $stable(reloadReg_r) && timeoutFlag_r)
		else $error("Protected reload was written.");
	sticky_bits_a: assert property (!chipRst && en_r && protect_r |=> en_r && protect_r)
		else $error("Set-only mode bit was cleared.");
	idle_hold_a: assert property (!running_r |-> counter_r == COUNT_RST)
		else $error("Counter left its reset value before starting.");

endmodule : wdog_timer

// ---- tb/wdog_apb_host.sv ----
`timescale 1ns/100ps
// ============================================================
// Processor side of the register bus, one transfer at a time.
// ============================================================
module wdog_apb_host
	import wdog_pkg::*;
(
	input wire logic core_clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [DW-1:0] prdata,
	output wdog_apb_req_t apbReq
);
	// The bus starts idle.
	initial begin
		apbReq = '0;
	end

	// Setup, access until ready, then release with inverted address and data.
	// The inversion keeps a stale value from passing for a fresh one.
	task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d,
		output logic [DW-1:0] rd, output logic err);
		@(negedge core_clk);
		apbReq = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(negedge core_clk);
		apbReq.penable = 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		@(negedge core_clk);
		apbReq = '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
	endtask : xfer
endmodule : wdog_apb_host

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
// ============================================================
// Self-checking bench of the windowed watchdog.
// ============================================================
module tb_top;
	import wdog_pkg::*;
	logic core_clk = 1'b0; // Bus clock, 50 ns.
	logic countClock = 1'b0; // Count clock, 200 ns, 37 ns offset.
	logic sys_rst = 1'b1; // External reset.
	logic chipRst = 1'b0; // Watchdog reset return path.
	wdog_apb_req_t apbReq; // Bus request from the host model.
	logic [DW-1:0] prdata; // Read data.
	logic pready; // Ready.
	logic pslverr; // Error.
	logic warnIrq; // Warning level.
	logic chipResetReq; // Reset request pulse.
	logic clockLock; // Oscillator lock.
	int failCount = 0; // Mismatches.
	int numChecks = 0; // Comparisons.
	int pulses = 0; // Reset request pulses seen.
	logic [DW-1:0] v; // Last read value.
	logic [DW-1:0] c0; // Earlier count read.
	logic e; // Last error flag.

	// ============================================================
	// Clocks, design and host model.
	// ============================================================
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	// Odd offset so count clock edges never fall on bus clock edges.
	initial begin
		#37;
		forever #100 countClock = ~countClock;
	end
	wdog_timer uut (.core_clk(core_clk), .sys_rst(sys_rst), .chipRst(chipRst), .countClock(countClock),
		.apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .warnIrq(warnIrq),
		.chipResetReq(chipResetReq), .clockLock(clockLock));
	wdog_apb_host host (.core_clk(core_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.apbReq(apbReq));
	// A one-cycle pulse is counted at the edge where it stands.
	always @(posedge core_clk) begin
		if (chipResetReq === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	// ============================================================
	// Shared tasks.
	// ============================================================
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		host.xfer(1'b1, a, d, v, e);
	endtask : wr
	task automatic rd(input logic [AW-1:0] a);
		host.xfer(1'b0, a, 32'h0, v, e);
	endtask : rd
	// Unlock pair; the start of counting needs it too.
	task automatic feed();
		wr(OFS_FEED, {24'h0, FEED_KEY1});
		wr(OFS_FEED, {24'h0, FEED_KEY2});
	endtask : feed
	// Settings need three count edges; a few bus clocks cover the sampling.
	task automatic waitCc(input int n);
		repeat (n) @(posedge countClock);
		repeat (4) @(negedge core_clk);
	endtask : waitCc
	task automatic doReset();
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (16) @(negedge core_clk);
		sys_rst = 1'b0;
	endtask : doReset
	task automatic testDone();
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : testDone

	// ============================================================
	// Scenarios.
	// ============================================================
	task automatic testResetValues();
		rd(OFS_MODE);
		check("mode", v, 32'h0);
		check("pready", 32'(pready), 32'h1);
		check("mapped err", 32'(e), 32'h0);
		rd(OFS_RELOAD);
		check("reload", v, 32'h000000FF);
		rd(OFS_WINDOW);
		check("window", v, 32'h00FFFFFF);
		rd(OFS_WARN);
		check("warn", v, 32'h0);
		waitCc(8);
		rd(OFS_COUNT);
		check("count idle", v, 32'h000000FF);
		rd(12'h010);
		check("unmapped err", 32'(e), 32'h1);
		$display("reset values done");
	endtask : testResetValues

	task automatic testRunWarnFeedErr();
		wr(OFS_RELOAD, 32'h00000010);
		wr(OFS_WARN, 32'h000000F8);
		wr(OFS_MODE, 32'h00000001);
		waitCc(4);
		feed();
		// Let a count edge refresh the snapshot, so a wrong load cannot hide behind the idle value.
		waitCc(1);
		rd(OFS_COUNT);
		c0 = v;
		check("min load", 32'(v <= 32'hFF && v >= 32'hFD), 32'h1);
		waitCc(16);
		rd(OFS_COUNT);
		check("step rate", 32'(c0 - v >= 3 && c0 - v <= 5), 32'h1);
		wr(OFS_MODE, 32'h0);
		rd(OFS_MODE);
		check("enable sticky", 32'(v[BIT_EN]), 32'h1);
		for (int i = 0; i < 2000 && warnIrq !== 1'b1; i++) begin
			@(negedge core_clk);
		end
		check("warnIrq", 32'(warnIrq), 32'h1);
		rd(OFS_MODE);
		check("warn flag", 32'(v[BIT_WARN]), 32'h1);
		wr(OFS_MODE, 32'h0);
		check("warn clear", 32'(warnIrq), 32'h0);
		wr(OFS_FEED, {24'h0, FEED_KEY1});
		wr(OFS_WARN, 32'h0);
		rd(OFS_MODE);
		check("feed error", 32'(v[BIT_TIMEOUT]), 32'h1);
		doReset();
		$display("run, warning and feed error done");
	endtask : testRunWarnFeedErr

	task automatic testWindowProtect();
		wr(OFS_RELOAD, 32'h00000100);
		wr(OFS_WINDOW, 32'h00000080);
		wr(OFS_MODE, 32'h00000001);
		waitCc(4);
		feed();
		feed();
		rd(OFS_MODE);
		check("early feed", 32'(v[BIT_TIMEOUT]), 32'h1);
		waitCc(4);
		wr(OFS_MODE, 32'h00000030);
		wr(OFS_MODE, 32'h0);
		rd(OFS_MODE);
		check("protect sticky", v, 32'h00000031);
		check("clockLock", 32'(clockLock), 32'h1);
		wr(OFS_RELOAD, 32'h00000200);
		rd(OFS_RELOAD);
		check("reload blocked", v, 32'h00000100);
		rd(OFS_MODE);
		check("blocked flag", 32'(v[BIT_TIMEOUT]), 32'h1);
		check("no pulse", 32'(pulses), 32'h0);
		doReset();
		$display("window and protection done");
	endtask : testWindowProtect

	task automatic testTimeout();
		wr(OFS_MODE, 32'h00000003);
		waitCc(4);
		feed();
		for (int i = 0; i < 6000 && pulses == 0; i++) begin
			@(negedge core_clk);
		end
		check("reset pulse", 32'(pulses), 32'h1);
		rd(OFS_MODE);
		check("timeout", v & 32'h7, 32'h7);
		chipRst = 1'b1;
		@(negedge core_clk);
		chipRst = 1'b0;
		rd(OFS_MODE);
		check("flag kept", v, 32'h00000004);
		wr(OFS_MODE, 32'h0);
		rd(OFS_MODE);
		check("flag cleared", v, 32'h0);
		$display("timeout done");
	endtask : testTimeout

	// Whole run takes well under a millisecond; four is ample.
	initial begin
		#4_000_000;
		failCount++;
		testDone();
	end

	initial begin
		doReset();
		testResetValues();
		testRunWarnFeedErr();
		testWindowProtect();
		testTimeout();
		testDone();
	end
endmodule : tb_top
